// ---- prot_check_pkg.sv ----
// constants and carrier types for the protection check result block
//////////////////////////////////////////////////////////////////////
// Contract
// - guest user write and read bits report guest user write permission, zero without virtualization
// - result bits 15..9, 7, 6 read zero; software writes zero there
// - boundary bit set when area contains 0000_0000 or 7FFF_FFFF, else cleared
// - combined supervisor execute: zero without virtualization, else host AND guest
// - combined supervisor write: zero without virtualization, else host AND guest
// - combined supervisor read: area permission, host AND guest under virtualization
// - combined user execute: area permission, host AND guest under virtualization
// - combined user write: area permission, host AND guest under virtualization
// - combined user read: area permission, host AND guest under virtualization
// - any write to command starts check of current bank; command reads zero
// - host permission bits 29..24 report host entries, zero without virtualization
package prot_check_pkg;

	localparam int unsigned N_ENTRIES = 4;

	// byte offsets on the register bus
	localparam logic [7:0] CMD_OFS    = 8'h00;
	localparam logic [7:0] RESULT_OFS = 8'h04;
	localparam logic [7:0] AREA_LO_OFS = 8'h08;
	localparam logic [7:0] AREA_HI_OFS = 8'h0C;
	localparam logic [7:0] CTRL_OFS   = 8'h10;
	localparam logic [7:0] ENTRY_OFS  = 8'h40;
	localparam logic [1:0] ENT_LO_FLD   = 2'h0;
	localparam logic [1:0] ENT_HI_FLD   = 2'h1;
	localparam logic [1:0] ENT_ATTR_FLD = 2'h2;

	// field positions
	localparam int unsigned CTRL_VIRT_BIT  = 0;
	localparam int unsigned CTRL_BANK_BIT  = 1;
	localparam int unsigned ATTR_GUEST_BIT = 8;
	localparam int unsigned ATTR_EN_BIT    = 9;
	localparam int unsigned ATTR_BANK_BIT  = 10;

	// writable bits of the result register
	localparam logic [31:0] RESULT_WMASK = 32'h3F3F_013F;
	localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;
	localparam logic [31:0] TOP_POSITIVE = 32'h7FFF_FFFF;

	// reset values
	localparam logic [31:0] AREA_RST = 32'h0000_0000;
	localparam logic        CTRL_RST = 1'b0;

	typedef struct packed {
		logic sx;
		logic sw;
		logic sr;
		logic ux;
		logic uw;
		logic ur;
	} perm_t;

	typedef struct packed {
		logic [1:0] rsv_hi;
		perm_t      host;
		logic [1:0] rsv_mid;
		perm_t      guest;
		logic [6:0] rsv_lo;
		logic       boundary_wrap_flag;
		logic [1:0] rsv_low;
		perm_t      comb;
	} result_t;

	typedef struct packed {
		logic [31:0] lo;
		logic [31:0] hi;
		perm_t       perm;
		logic        guest;
		logic        enabled;
		logic        bank;
	} entry_t;

endpackage

// ---- area_permission_eval.sv ----
// evaluates one protection check over the entry table
`timescale 1ns/1ps
module area_permission_eval (
	input  wire logic                                        clk,
	input  wire logic                                        rst_n,
	input  wire logic                                        start,
	input  wire logic [31:0]                                 area_lo,
	input  wire logic [31:0]                                 area_hi,
	input  wire logic                                        virt_en,
	input  wire logic                                        bank,
	input  wire prot_check_pkg::entry_t [prot_check_pkg::N_ENTRIES-1:0] entries,
	output prot_check_pkg::result_t                          res,
	output logic                                             done
);
	logic [prot_check_pkg::N_ENTRIES-1:0] covers;
	prot_check_pkg::perm_t   host_p;
	prot_check_pkg::perm_t   guest_p;
	prot_check_pkg::perm_t   any_p;
	prot_check_pkg::result_t res_d;
	prot_check_pkg::result_t res_q;
	logic                    done_q;

	//////////////////////////////////////////////////////////////////
	genvar i;
	for (i = 0; i < prot_check_pkg::N_ENTRIES; i++) begin : g_ent
		// only entries of the selected bank take part
		assign covers[i] = entries[i].enabled && (entries[i].bank == bank)
			&& (area_lo >= entries[i].lo) && (area_hi <= entries[i].hi);
	end

	always_comb begin
		host_p  = '0;
		guest_p = '0;
		any_p   = '0;
		for (int k = 0; k < prot_check_pkg::N_ENTRIES; k++) begin
			if (covers[k]) begin
				any_p = any_p | entries[k].perm;
				if (entries[k].guest) begin
					guest_p = guest_p | entries[k].perm;
				end else begin
					host_p = host_p | entries[k].perm;
				end
			end
		end
	end

	always_comb begin
		res_d = '0;
		if (virt_en) begin
			res_d.host     = host_p;
			res_d.guest    = guest_p;
			res_d.guest.ur = guest_p.uw;
			// combined bits follow the reported guest bits, so a set
			// combined bit always shows both host and guest bits set
			res_d.comb     = host_p & res_d.guest;
		end else begin
			res_d.comb    = any_p;
			res_d.comb.sx = 1'b0;
			res_d.comb.sw = 1'b0;
		end
		res_d.boundary_wrap_flag = (area_lo == prot_check_pkg::ZERO_WORD)
			|| ((area_lo <= prot_check_pkg::TOP_POSITIVE)
			&& (area_hi >= prot_check_pkg::TOP_POSITIVE));
	end

	//////////////////////////////////////////////////////////////////
	// no reset: contents mean nothing until the first check
	always_ff @(posedge clk) begin
		if (start) begin
			res_q <= res_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			done_q <= 1'b0;
		end else begin
			done_q <= start;
		end
	end

	assign res  = res_q;
	assign done = done_q;

	a_done_follows: assert property (@(posedge clk) disable iff (!rst_n)
		start |=> done) else $error("done did not follow start");
endmodule

// ---- protection_check_result.sv ----
// ahb-lite slave holding the protection check command, result and setup registers
//
// The AHB-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module protection_check_result (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata
);
	logic [7:0]  addr_q;
	logic        wr_q;
	logic        rd_q;
	logic        hready_q;
	logic [31:0] hrdata_q;
	logic [31:0] rd_data;
	logic        accept;
	logic        do_wr;
	logic        cmd_wr;
	logic [31:0] area_lo_q;
	logic [31:0] area_hi_q;
	logic        virtualization_enable;
	logic        protection_bank_select;
	prot_check_pkg::entry_t [prot_check_pkg::N_ENTRIES-1:0] entry_q;
	prot_check_pkg::result_t protection_check_result_q;
	prot_check_pkg::result_t chk_res;
	logic                    chk_done;

	//////////////////////////////////////////////////////////////////
	// bus front end: writes need no wait, reads take one wait state; a read
	// issued back to back with a command still returns the previous result
	assign accept = hsel && htrans[1] && hready;
	assign do_wr  = wr_q && hready_q;
	assign cmd_wr = do_wr && (addr_q == prot_check_pkg::CMD_OFS);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_q <= 8'h00;
			wr_q   <= 1'b0;
			rd_q   <= 1'b0;
		end else begin
			if (accept) begin
				addr_q <= {haddr[7:2], 2'b00};
			end
			wr_q <= accept && hwrite;
			rd_q <= accept && !hwrite;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hready_q <= 1'b1;
			hrdata_q <= 32'h0000_0000;
		end else begin
			hready_q <= !(accept && !hwrite);
			if (rd_q) begin
				hrdata_q <= rd_data;
			end
		end
	end

	always_comb begin
		rd_data = 32'h0000_0000;
		// same window as the write decode, so offsets above it read zero
		if (addr_q[7:6] == prot_check_pkg::ENTRY_OFS[7:6]) begin
			if (addr_q[3:2] == prot_check_pkg::ENT_LO_FLD) begin
				rd_data = entry_q[addr_q[5:4]].lo;
			end else if (addr_q[3:2] == prot_check_pkg::ENT_HI_FLD) begin
				rd_data = entry_q[addr_q[5:4]].hi;
			end else if (addr_q[3:2] == prot_check_pkg::ENT_ATTR_FLD) begin
				rd_data[5:0] = entry_q[addr_q[5:4]].perm;
				rd_data[prot_check_pkg::ATTR_GUEST_BIT] = entry_q[addr_q[5:4]].guest;
				rd_data[prot_check_pkg::ATTR_EN_BIT]    = entry_q[addr_q[5:4]].enabled;
				rd_data[prot_check_pkg::ATTR_BANK_BIT]  = entry_q[addr_q[5:4]].bank;
			end
		end else begin
			unique case (addr_q)
				prot_check_pkg::CMD_OFS: begin
					rd_data = 32'h0000_0000;
				end
				prot_check_pkg::RESULT_OFS: begin
					rd_data = protection_check_result_q & prot_check_pkg::RESULT_WMASK;
				end
				prot_check_pkg::AREA_LO_OFS: begin
					rd_data = area_lo_q;
				end
				prot_check_pkg::AREA_HI_OFS: begin
					rd_data = area_hi_q;
				end
				prot_check_pkg::CTRL_OFS: begin
					rd_data[prot_check_pkg::CTRL_VIRT_BIT] = virtualization_enable;
					rd_data[prot_check_pkg::CTRL_BANK_BIT] = protection_bank_select;
				end
				default: begin
					rd_data = 32'h0000_0000;
				end
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////
	// setup registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			area_lo_q              <= prot_check_pkg::AREA_RST;
			area_hi_q              <= prot_check_pkg::AREA_RST;
			virtualization_enable  <= prot_check_pkg::CTRL_RST;
			protection_bank_select <= prot_check_pkg::CTRL_RST;
		end else if (do_wr) begin
			if (addr_q == prot_check_pkg::AREA_LO_OFS) begin
				area_lo_q <= hwdata;
			end
			if (addr_q == prot_check_pkg::AREA_HI_OFS) begin
				area_hi_q <= hwdata;
			end
			if (addr_q == prot_check_pkg::CTRL_OFS) begin
				virtualization_enable  <= hwdata[prot_check_pkg::CTRL_VIRT_BIT];
				protection_bank_select <= hwdata[prot_check_pkg::CTRL_BANK_BIT];
			end
		end
	end

	genvar e;
	for (e = 0; e < prot_check_pkg::N_ENTRIES; e++) begin : g_entry
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				entry_q[e] <= '0;
			end else if (do_wr && (addr_q[7:6] == prot_check_pkg::ENTRY_OFS[7:6])
				&& (addr_q[5:4] == 2'(e))) begin
				if (addr_q[3:2] == prot_check_pkg::ENT_LO_FLD) begin
					entry_q[e].lo <= hwdata;
				end
				if (addr_q[3:2] == prot_check_pkg::ENT_HI_FLD) begin
					entry_q[e].hi <= hwdata;
				end
				if (addr_q[3:2] == prot_check_pkg::ENT_ATTR_FLD) begin
					entry_q[e].perm    <= hwdata[5:0];
					entry_q[e].guest   <= hwdata[prot_check_pkg::ATTR_GUEST_BIT];
					entry_q[e].enabled <= hwdata[prot_check_pkg::ATTR_EN_BIT];
					entry_q[e].bank    <= hwdata[prot_check_pkg::ATTR_BANK_BIT];
				end
			end
		end
	end

	//////////////////////////////////////////////////////////////////
	area_permission_eval u_eval (
		.clk     (clk),
		.rst_n   (rst_n),
		.start   (cmd_wr),
		.area_lo (area_lo_q),
		.area_hi (area_hi_q),
		.virt_en (virtualization_enable),
		.bank    (protection_bank_select),
		.entries (entry_q),
		.res     (chk_res),
		.done    (chk_done)
	);

	// a finishing check wins over a software write in the same cycle;
	// left unreset since it is undefined until the first check
	always_ff @(posedge clk) begin
		if (chk_done) begin
			protection_check_result_q <= chk_res;
		end else if (do_wr && (addr_q == prot_check_pkg::RESULT_OFS)) begin
			protection_check_result_q <= hwdata & prot_check_pkg::RESULT_WMASK;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	assign hreadyout = hready_q;
	assign hrdata    = hrdata_q;

	//////////////////////////////////////////////////////////////////
	a_guest_user_bits: assert property (@(posedge clk) disable iff (!rst_n)
		chk_done |-> (chk_res.guest.ur == chk_res.guest.uw)
		&& ($past(virtualization_enable) || (chk_res.guest == '0)))
		else $error("guest user bits wrong");
	a_reserved_read_zero: assert property (@(posedge clk) disable iff (!rst_n)
		rd_q && (addr_q == prot_check_pkg::RESULT_OFS)
		|=> (hrdata[15:9] == 7'h00) && (hrdata[7:6] == 2'h0) && hreadyout)
		else $error("reserved result bits not zero");
	a_boundary_flag: assert property (@(posedge clk) disable iff (!rst_n)
		cmd_wr |=> chk_res.boundary_wrap_flag == (($past(area_lo_q) == 32'h0000_0000)
		|| (($past(area_lo_q) <= 32'h7FFF_FFFF) && ($past(area_hi_q) >= 32'h7FFF_FFFF))))
		else $error("boundary flag wrong");
	a_super_exec_comb: assert property (@(posedge clk) disable iff (!rst_n)
		chk_done |-> chk_res.comb.sx == ($past(virtualization_enable)
		&& chk_res.host.sx && chk_res.guest.sx))
		else $error("combined supervisor execute wrong");
	a_super_write_comb: assert property (@(posedge clk) disable iff (!rst_n)
		chk_done |-> chk_res.comb.sw == ($past(virtualization_enable)
		&& chk_res.host.sw && chk_res.guest.sw))
		else $error("combined supervisor write wrong");
	a_super_read_comb: assert property (@(posedge clk) disable iff (!rst_n)
		chk_done && $past(virtualization_enable)
		|-> chk_res.comb.sr == (chk_res.host.sr && chk_res.guest.sr))
		else $error("combined supervisor read wrong");
	a_user_exec_comb: assert property (@(posedge clk) disable iff (!rst_n)
		chk_done && $past(virtualization_enable)
		|-> chk_res.comb.ux == (chk_res.host.ux && chk_res.guest.ux))
		else $error("combined user execute wrong");
	a_user_write_comb: assert property (@(posedge clk) disable iff (!rst_n)
		chk_done && $past(virtualization_enable)
		|-> chk_res.comb.uw == (chk_res.host.uw && chk_res.guest.uw))
		else $error("combined user write wrong");
	a_user_read_comb: assert property (@(posedge clk) disable iff (!rst_n)
		chk_done && $past(virtualization_enable)
		|-> chk_res.comb.ur == (chk_res.host.ur && chk_res.guest.ur))
		else $error("combined user read wrong");
	a_cmd_stores_result: assert property (@(posedge clk) disable iff (!rst_n)
		cmd_wr |=> chk_done ##1 (protection_check_result_q == $past(chk_res)))
		else $error("check result not stored");
	a_cmd_reads_zero: assert property (@(posedge clk) disable iff (!rst_n)
		rd_q && (addr_q == prot_check_pkg::CMD_OFS) |=> hrdata == 32'h0000_0000)
		else $error("command read not zero");
	a_host_bits_off: assert property (@(posedge clk) disable iff (!rst_n)
		chk_done && !$past(virtualization_enable) |-> chk_res.host == '0)
		else $error("host bits set without virtualization");
	a_read_one_wait: assert property (@(posedge clk) disable iff (!rst_n)
		accept && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");

	c_check_virt: cover property (@(posedge clk) disable iff (!rst_n)
		chk_done && virtualization_enable && chk_res.comb.sx);
	c_check_plain: cover property (@(posedge clk) disable iff (!rst_n)
		chk_done && !virtualization_enable && chk_res.comb.ur);
	c_boundary_hit: cover property (@(posedge clk) disable iff (!rst_n)
		chk_done && chk_res.boundary_wrap_flag);
endmodule

// ---- protection_check_result_tb.sv ----
// self-checking testbench for the protection check result register block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
	num_checks++; \
	if ((got) !== (ex)) begin \
		error_cnt++; \
		$display("[ERR] %s expected %h seen %h", nm, ex, got); \
	end \
end

module protection_check_result_tb;
	logic        clk;
	logic        rst_n;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	int          error_cnt;
	int          num_checks;

	// single slave, so its own ready is the bus ready
	protection_check_result i_protection_check_result (
		.clk       (clk),
		.rst_n     (rst_n),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hreadyout),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	//////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// one single transfer; ready is judged on the value sampled at the edge
	task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
			output logic [31:0] rdv);
		hsel   <= 1'h1;
		haddr  <= {24'h00_0000, ofs};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize  <= 3'h2;
		@(posedge clk);
		while (hreadyout !== 1'h1) @(posedge clk);
		hsel   <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk);
		while (hreadyout !== 1'h1) @(posedge clk);
		rdv = hrdata;
		`CHK("response", 1'h0, hresp)
	endtask

	task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
		logic [31:0] dummy;
		bus(1'h1, ofs, d, dummy);
	endtask

	task automatic expect_rd(input logic [7:0] ofs, input logic [31:0] ex, input string nm);
		logic [31:0] v;
		bus(1'h0, ofs, 32'h0000_0000, v);
		`CHK(nm, ex, v)
	endtask

	task automatic set_entry(input logic [1:0] i, input logic [31:0] lo, hi, attr);
		logic [7:0] base;
		base = prot_check_pkg::ENTRY_OFS + {2'h0, i, 4'h0};
		wr(base + {4'h0, prot_check_pkg::ENT_LO_FLD, 2'h0}, lo);
		wr(base + {4'h0, prot_check_pkg::ENT_HI_FLD, 2'h0}, hi);
		wr(base + {4'h0, prot_check_pkg::ENT_ATTR_FLD, 2'h0}, attr);
	endtask

	// command write, then the result read after the idle cycle that the bus task leaves
	task automatic run_check(input logic [31:0] lo, hi, ctrl, ex);
		wr(prot_check_pkg::AREA_LO_OFS, lo);
		wr(prot_check_pkg::AREA_HI_OFS, hi);
		wr(prot_check_pkg::CTRL_OFS, ctrl);
		wr(prot_check_pkg::CMD_OFS, 32'hA5A5_5A5A);
		expect_rd(prot_check_pkg::RESULT_OFS, ex, "result");
	endtask

	//////////////////////////////////////////////////////////////////////
	task automatic t_reset_state();
		`CHK("hreadyout", 1'h1, hreadyout)
		`CHK("hrdata", 32'h0000_0000, hrdata)
		expect_rd(prot_check_pkg::AREA_LO_OFS, prot_check_pkg::AREA_RST, "area lo");
		expect_rd(prot_check_pkg::CTRL_OFS, 32'h0000_0000, "control");
	endtask

	task automatic t_map();
		wr(prot_check_pkg::AREA_LO_OFS, 32'h1234_5678);
		expect_rd(prot_check_pkg::AREA_LO_OFS, 32'h1234_5678, "area lo");
		wr(prot_check_pkg::AREA_HI_OFS, 32'h8765_4321);
		expect_rd(prot_check_pkg::AREA_HI_OFS, 32'h8765_4321, "area hi");
		expect_rd(prot_check_pkg::CMD_OFS, 32'h0000_0000, "command");
		wr(8'h4C, 32'hFFFF_FFFF);
		expect_rd(8'h4C, 32'h0000_0000, "unmapped");
	endtask

	// bank 0 host perms sx,sw,ux,uw, guest perms sx,sr,ux,uw; bank 1 host perms all; a disabled entry with all bits grants nothing
	task automatic t_entries();
		set_entry(2'h0, 32'h0000_1000, 32'h0000_1FFF, 32'h0000_0236);
		set_entry(2'h1, 32'h0000_1000, 32'h0000_1FFF, 32'h0000_032E);
		set_entry(2'h2, 32'h0000_1000, 32'h0000_1FFF, 32'h0000_063F);
		set_entry(2'h3, 32'h0000_1000, 32'h0000_1FFF, 32'h0000_003F);
		expect_rd(8'h40, 32'h0000_1000, "entry lo");
		expect_rd(8'h44, 32'h0000_1FFF, "entry hi");
		expect_rd(8'h68, 32'h0000_063F, "entry attr");
		expect_rd(8'h80, 32'h0000_0000, "unmapped high");
	endtask

	task automatic t_virt_on();
		run_check(32'h0000_1100, 32'h0000_1200, 32'h1, 32'h362F_0026);
	endtask

	// bank one holds only a host entry, so the combined bits stay clear
	task automatic t_bank();
		run_check(32'h0000_1100, 32'h0000_1200, 32'h3, 32'h3F00_0000);
	endtask

	// without virtualization supervisor execute and write are forced low
	task automatic t_virt_off();
		run_check(32'h0000_1100, 32'h0000_1200, 32'h0, 32'h0000_000E);
		run_check(32'h0000_1100, 32'h0000_1200, 32'h2, 32'h0000_000F);
	endtask

	task automatic t_boundary();
		logic [31:0] lo_t[5];
		logic [31:0] hi_t[5];
		logic [31:0] ex_t[5];
		lo_t = '{32'h0000_0000, 32'h7FFF_0000, 32'h7FFF_FFFF, 32'h8000_0000, 32'h0000_0F00};
		hi_t = '{32'h0000_0010, 32'h8000_0010, 32'h7FFF_FFFF, 32'h8000_0100, 32'h0000_1100};
		ex_t = '{32'h0000_0100, 32'h0000_0100, 32'h0000_0100, 32'h0000_0000, 32'h0000_0000};
		for (int k = 0; k < 5; k++) begin
			run_check(lo_t[k], hi_t[k], 32'h1, ex_t[k]);
		end
	endtask

	task automatic t_reserved();
		// software keeps reserved bits at zero when it writes
		wr(prot_check_pkg::RESULT_OFS, prot_check_pkg::RESULT_WMASK);
		expect_rd(prot_check_pkg::RESULT_OFS, prot_check_pkg::RESULT_WMASK, "writable");
		wr(prot_check_pkg::RESULT_OFS, 32'h0000_0000);
		expect_rd(prot_check_pkg::RESULT_OFS, 32'h0000_0000, "cleared");
	endtask

	// a second reset in mid-run must return the control register to zero
	task automatic t_mid_reset();
		wr(prot_check_pkg::CTRL_OFS, 32'h0000_0003);
		expect_rd(prot_check_pkg::CTRL_OFS, 32'h0000_0003, "control set");
		rst_n <= 1'h0;
		@(posedge clk);
		@(posedge clk);
		`CHK("hreadyout", 1'h1, hreadyout)
		rst_n <= 1'h1;
		@(posedge clk);
		expect_rd(prot_check_pkg::CTRL_OFS, 32'h0000_0000, "control");
	endtask

	//////////////////////////////////////////////////////////////////////
	initial begin
		rst_n      = 1'h0;
		hsel       = 1'h0;
		haddr      = 32'h0000_0000;
		htrans     = 2'h0;
		hwrite     = 1'h0;
		hsize      = 3'h2;
		hwdata     = 32'h0000_0000;
		error_cnt  = 0;
		num_checks = 0;
		repeat (4) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		t_reset_state();
		t_map();
		t_entries();
		t_virt_on();
		t_bank();
		t_virt_off();
		t_boundary();
		t_reserved();
		t_mid_reset();
		report_and_stop();
	end

	// the whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		report_and_stop();
	end
endmodule
